// [core/ckp_pkg.sv]
// package: constants for the clock prescaler and speed select block
package ckp_pkg;
   // register addresses
   localparam logic [7:0] CKP_ADDR_SPEED_CTRL = 8'h8f;
   localparam logic [7:0] CKP_ADDR_RELOAD     = 8'h97;
   localparam logic [7:0] CKP_ADDR_SPI_CTRL   = 8'haf;
   // reset values and reload limit
   localparam logic [7:0] CKP_RELOAD_RST      = 8'hff;
   localparam logic [7:0] CKP_RELOAD_MAX      = 8'hff;
   localparam logic [6:0] CKP_SPEED_FAST_RST  = 7'h00;
   localparam logic       CKP_SPI_FAST_RST    = 1'b0;
   // field positions in the speed control and spi control registers
   localparam int CKP_BIT_DOUBLE_SPEED   = 0;
   localparam int CKP_BIT_TIMER_ZERO     = 1;
   localparam int CKP_BIT_TIMER_ONE      = 2;
   localparam int CKP_BIT_TIMER_TWO      = 3;
   localparam int CKP_BIT_UART           = 4;
   localparam int CKP_BIT_COUNTER_ARRAY  = 5;
   localparam int CKP_BIT_WATCHDOG       = 6;
   localparam int CKP_BIT_SPI            = 0;
   // oscillator periods per machine cycle
   localparam logic [3:0] CKP_PERIODS_STD  = 4'hc;
   localparam logic [3:0] CKP_PERIODS_FAST = 4'h6;
   // number of peripheral clock selects
   localparam int CKP_NUM_PERIPH = 7;
endpackage : ckp_pkg

// [core/ckp_div_if.sv]
// interface: prescaler control from the top to the divider
`timescale 1ns/10ps
interface ckp_div_if;
   logic       half_tick;
   logic       osc_tick;
   logic       double_speed;
   logic [7:0] reload;
   logic       tick;
   modport top (output half_tick, output osc_tick, output double_speed, output reload,
                input tick);
   modport div (input half_tick, input osc_tick, input double_speed, input reload,
                output tick);
endinterface : ckp_div_if

// [core/ckp_divider.sv]
// reload divider producing the prescaled clock tick
`timescale 1ns/10ps
module ckp_divider
   import ckp_pkg::*;
(
   input  wire logic i_clock,
   input  wire logic i_rst,
   ckp_div_if.div    bus
);
   typedef struct packed {
      logic [7:0] cnt;
      logic       phase;
      logic       tick;
   } ckp_div_st_t;

   ckp_div_st_t st_r;
   ckp_div_st_t st_nxt;
   logic        step;

   always_comb begin
      st_nxt      = st_r;
      st_nxt.tick = 1'b0;
      // double speed steps on every crystal rise, standard on every second one
      step = bus.double_speed ? bus.osc_tick : bus.half_tick;
      if (step) begin
         if (bus.reload == CKP_RELOAD_MAX) begin
            st_nxt.tick = 1'b1;
            st_nxt.cnt  = bus.reload;
         end else if (st_r.cnt == CKP_RELOAD_MAX) begin
            // new reload only here, except all ones, which applies on the next step and can cut a running pulse short
            // start one above reload: each half period is 255 minus reload steps
            st_nxt.cnt   = bus.reload + 8'h01;
            st_nxt.phase = ~st_r.phase;
            st_nxt.tick  = st_r.phase;
         end else begin
            st_nxt.cnt = st_r.cnt + 8'h01;
         end
      end
   end

   always_ff @(posedge i_clock or posedge i_rst) begin
      if (i_rst) begin
         st_r <= '{cnt: CKP_RELOAD_RST, phase: 1'b0, tick: 1'b0};
      end else begin
         st_r <= st_nxt;
      end
   end

   assign bus.tick = st_r.tick;
endmodule : ckp_divider

// [core/ckp_clock_prescaler.sv]
// top: clock prescaler, speed mode select and fast-clock control registers
//
// Contract
// - reset loads reload value with all ones
// - any written reload value divides the clock, except all ones in double speed (ratio one)
// - reload zero gives 1020 or 510 ratio
// - reload all ones gives two or one
// - double speed divides by 2*(255-reload)
// - standard divides by 4*(255-reload)
// - double speed: six periods per machine cycle
// - divide-by-two stage, bypassed in double speed
// - mode change applied on half-clock rising edge
// - bit 0 selects twelve or six periods
// - mode bit loaded from fuse after reset
// - fast-clock bits 6..1, spi bit 0
// - fast bits ignored unless double speed; 0=fast
// - spi register resets with bit 0 clear
// - reload register at 97h, resets all ones
`timescale 1ns/10ps
module ckp_clock_prescaler
   import ckp_pkg::*;
(
   // clock and reset
   input  wire logic       i_clock,
   input  wire logic       i_rst,
   // oscillator and fuse
   input  wire logic       i_crystal_input,
   input  wire logic       i_config_fuse_double_speed,
   // register port
   input  wire logic [7:0] i_addr,
   input  wire logic [7:0] i_wdata,
   input  wire logic       i_wr,
   input  wire logic       i_rd,
   output logic      [7:0] o_rdata,
   // clock outputs
   output logic            o_core_tick,
   output logic            o_double_speed_mode,
   output logic      [3:0] o_machine_periods,
   output logic      [6:0] o_periph_fast
);
   // ****************************************************
   // state
   // ****************************************************
   typedef struct packed {
      logic       xi_s1;
      logic       xi_s2;
      logic       xi_prev;
      logic       half;
      logic       fuse_s1;
      logic       fuse_s2;
      logic       fuse_v1;
      logic       fuse_v2;
      logic       fuse_loaded;
      logic       mode_req;
      logic       mode_act;
      logic [6:1] fast;
      logic       spi_fast;
      logic [7:0] reload;
      logic [7:0] rdata;
      logic       tick;
      logic [3:0] periods;
      logic [6:0] pfast;
   } ckp_st_t;

   ckp_st_t    st_r;
   ckp_st_t    st_nxt;
   logic       xi_rise;
   logic       half_rise;
   logic [6:0] fast_sel;

   ckp_div_if  dv ();

   // ****************************************************
   // divider
   // ****************************************************
   assign dv.half_tick    = half_rise;
   assign dv.osc_tick     = xi_rise;
   assign dv.double_speed = st_r.mode_act;
   assign dv.reload       = st_r.reload;

   ckp_divider u_div (
      .i_clock (i_clock),
      .i_rst   (i_rst),
      .bus     (dv.div)
   );

   // ****************************************************
   // next state
   // ****************************************************
   always_comb begin
      st_nxt       = st_r;
      // two-stage synchroniser for the crystal pin
      st_nxt.xi_s1 = i_crystal_input;
      st_nxt.xi_s2 = st_r.xi_s1;
      st_nxt.xi_prev = st_r.xi_s2;
      xi_rise   = st_r.xi_s2 & ~st_r.xi_prev;
      // divide-by-two stage on the crystal input
      half_rise = xi_rise & ~st_r.half;
      if (xi_rise) begin
         st_nxt.half = ~st_r.half;
      end
      // fuse pin synchronised; loaded once both stages hold a post-reset sample
      // limitation: a mode write in the first two cycles is overwritten
      st_nxt.fuse_s1 = i_config_fuse_double_speed;
      st_nxt.fuse_s2 = st_r.fuse_s1;
      st_nxt.fuse_v1 = 1'b1;
      st_nxt.fuse_v2 = st_r.fuse_v1;
      if (st_r.fuse_v2 && !st_r.fuse_loaded) begin
         st_nxt.fuse_loaded = 1'b1;
         st_nxt.mode_req    = st_r.fuse_s2;
      end
      // mode change only on a rising edge of the halved crystal
      if (half_rise) begin
         st_nxt.mode_act = st_r.mode_req;
      end
      if (i_wr) begin
         case (i_addr)
            CKP_ADDR_SPEED_CTRL: begin
               // bit 7 is reserved and not stored
               st_nxt.mode_req = i_wdata[CKP_BIT_DOUBLE_SPEED];
               st_nxt.fast     = i_wdata[6:1];
            end
            CKP_ADDR_SPI_CTRL: begin
               st_nxt.spi_fast = i_wdata[CKP_BIT_SPI];
            end
            CKP_ADDR_RELOAD: begin
               st_nxt.reload = i_wdata;
            end
            default: begin
            end
         endcase
      end
      st_nxt.rdata = 8'h00;
      if (i_rd) begin
         case (i_addr)
            CKP_ADDR_SPEED_CTRL: st_nxt.rdata = {1'b0, st_r.fast, st_r.mode_req};
            CKP_ADDR_SPI_CTRL:   st_nxt.rdata = {7'h00, st_r.spi_fast};
            CKP_ADDR_RELOAD:     st_nxt.rdata = st_r.reload;
            default:             st_nxt.rdata = 8'h00;
         endcase
      end
      st_nxt.tick    = dv.tick;
      st_nxt.periods = st_r.mode_act ? CKP_PERIODS_FAST : CKP_PERIODS_STD;
      // fast only in double speed and with the bit cleared
      fast_sel = {st_r.fast, st_r.spi_fast};
      for (int i = 0; i < CKP_NUM_PERIPH; i++) begin
         st_nxt.pfast[i] = st_r.mode_act & ~fast_sel[i];
      end
   end

   // ****************************************************
   // registers
   // ****************************************************
   always_ff @(posedge i_clock or posedge i_rst) begin
      if (i_rst) begin
         st_r <= '{xi_s1: 1'b0, xi_s2: 1'b0, xi_prev: 1'b0, half: 1'b0,
                   fuse_s1: 1'b0, fuse_s2: 1'b0, fuse_v1: 1'b0, fuse_v2: 1'b0,
                   fuse_loaded: 1'b0, mode_req: 1'b0, mode_act: 1'b0,
                   fast: CKP_SPEED_FAST_RST[6:1], spi_fast: CKP_SPI_FAST_RST,
                   reload: CKP_RELOAD_RST, rdata: 8'h00, tick: 1'b0,
                   periods: CKP_PERIODS_STD, pfast: 7'h00};
      end else begin
         st_r <= st_nxt;
      end
   end

   assign o_rdata             = st_r.rdata;
   assign o_core_tick         = st_r.tick;
   assign o_double_speed_mode = st_r.mode_act;
   assign o_machine_periods   = st_r.periods;
   // pfast bit 0 is spi, bits 6..1 match register bits
   assign o_periph_fast       = st_r.pfast;
endmodule : ckp_clock_prescaler

// [verif/ckp_xtal_model.sv]
// partner: free-running crystal oscillator on the crystal pin
`timescale 1ns/10ps
module ckp_xtal_model #(
   parameter int HALF_NS = 160
) (
   output logic o_crystal
);
   // offset keeps crystal edges away from system clock edges
   initial begin
      o_crystal = 1'b0;
      #7;
      forever #(HALF_NS) o_crystal = ~o_crystal;
   end
endmodule : ckp_xtal_model

// [verif/ckp_clock_prescaler_props.sv]
// checker: port relations of the clock prescaler
`timescale 1ns/10ps
module ckp_props
   import ckp_pkg::*;
(
   // clock, reset and pins
   input wire logic       i_clock, i_rst, i_crystal_input, i_config_fuse_double_speed,
   // register port
   input wire logic [7:0] i_addr, i_wdata, o_rdata,
   input wire logic       i_wr, i_rd,
   // clock outputs
   input wire logic       o_core_tick, o_double_speed_mode,
   input wire logic [3:0] o_machine_periods,
   input wire logic [6:0] o_periph_fast
);
   default clocking @(posedge i_clock); endclocking
   default disable iff (i_rst);
   logic [7:0] reload_r;
   logic       mapped;
   assign mapped = i_addr inside {CKP_ADDR_SPEED_CTRL, CKP_ADDR_RELOAD, CKP_ADDR_SPI_CTRL};
   always_ff @(posedge i_clock or posedge i_rst) begin
      if (i_rst) reload_r <= CKP_RELOAD_RST;
      else if (i_wr && i_addr == CKP_ADDR_RELOAD) reload_r <= i_wdata;
   end
   a_reload_readback: assert property (
      i_rd && i_addr == CKP_ADDR_RELOAD |=> o_rdata == reload_r) else $error("reload readback");
   a_rdata_idle: assert property (!$past(i_rd) |-> o_rdata == 8'h00)
      else $error("read data not idle");
   a_unmapped_zero: assert property (i_rd && !mapped |=> o_rdata == 8'h00)
      else $error("unmapped read not zero");
   a_spi_reserved: assert property (
      i_rd && i_addr == CKP_ADDR_SPI_CTRL |=> o_rdata[7:1] == 7'h00) else $error("spi reserved");
   a_speed_reserved: assert property (
      i_rd && i_addr == CKP_ADDR_SPEED_CTRL |=> !o_rdata[7]) else $error("speed bit 7 set");
   a_periods_mode: assert property ($stable(o_double_speed_mode) |->
      o_machine_periods == (o_double_speed_mode ? CKP_PERIODS_FAST : CKP_PERIODS_STD))
      else $error("periods do not match mode");
   a_fast_gated: assert property (
      !o_double_speed_mode && !$past(o_double_speed_mode) |-> o_periph_fast == 7'h00)
      else $error("fast bits active in standard mode");
   a_std_tick_gap: assert property (
      !o_double_speed_mode [*3] ##0 o_core_tick ##1 !o_double_speed_mode |-> !o_core_tick)
      else $error("back to back ticks in standard mode");
endmodule : ckp_props
bind ckp_clock_prescaler ckp_props u_props (.i_clock(i_clock), .i_rst(i_rst),
   .i_crystal_input(i_crystal_input), .i_config_fuse_double_speed(i_config_fuse_double_speed),
   .i_addr(i_addr), .i_wdata(i_wdata), .o_rdata(o_rdata), .i_wr(i_wr), .i_rd(i_rd),
   .o_core_tick(o_core_tick), .o_double_speed_mode(o_double_speed_mode),
   .o_machine_periods(o_machine_periods), .o_periph_fast(o_periph_fast));

// [verif/tb.sv]
// testbench: clock prescaler scenarios
`timescale 1ns/10ps
module tb
   import ckp_pkg::*;
();
   logic       clock = 1'b0, rst = 1'b1, fuse = 1'b0, wr = 1'b0, rd = 1'b0;
   logic [7:0] addr = 8'h00, wdata = 8'h00, rdata;
   logic       xtal, tick, mode;
   logic [3:0] per;
   logic [6:0] fast;
   int         mismatches = 0, checked = 0, n;
   initial forever #20 clock = ~clock;
   ckp_xtal_model xm (.o_crystal(xtal));
   ckp_clock_prescaler uut (.i_clock(clock), .i_rst(rst), .i_crystal_input(xtal),
      .i_config_fuse_double_speed(fuse), .i_addr(addr), .i_wdata(wdata), .i_wr(wr),
      .i_rd(rd), .o_rdata(rdata), .o_core_tick(tick), .o_double_speed_mode(mode),
      .o_machine_periods(per), .o_periph_fast(fast));
   task automatic test_done();
      $display("mismatches %0d checked %0d", mismatches, checked);
      if (mismatches == 0 && checked > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask : test_done
   task automatic chk(input logic [15:0] g, input logic [15:0] e);
      checked++;
      if (g !== e) begin
         mismatches++;
         $display("Error at %0t: got %h expected %h", $time, g, e);
      end
   endtask : chk
   task automatic wrr(input logic [7:0] a, input logic [7:0] v);
      @(posedge clock);
      addr  <= a;
      wdata <= v;
      wr    <= 1'b1;
      @(posedge clock);
      wr    <= 1'b0;
   endtask : wrr
   task automatic rdc(input logic [7:0] a, input logic [7:0] e);
      @(posedge clock);
      addr <= a;
      rd   <= 1'b1;
      @(posedge clock);
      rd   <= 1'b0;
      #1 chk({8'h00, rdata}, {8'h00, e});
   endtask : rdc
   // bounded wait for a tick or for the mode level
   task automatic wt(input logic m, input int lim);
      n = 0;
      do begin
         @(posedge clock);
         #1 n++;
      end while ((m ? (mode !== wdata[0]) : (tick !== 1'b1)) && n < lim);
      if (n >= lim) begin
         mismatches++;
         test_done();
      end
   endtask : wt
   // steps per tick times cycles per step; the first tick after a rewrite may be stale
   task automatic period(input logic [7:0] r, input int m);
      repeat (4) wt(1'b0, 9000);
      chk(16'(n), 16'(m * ((r == 8'hff) ? 1 : 2 * (255 - int'(r)))));
   endtask : period
   task automatic mode_to(input logic [7:0] v);
      wrr(CKP_ADDR_SPEED_CTRL, v);
      #1 chk(16'(mode), {15'h0, ~v[0]});
      wt(1'b1, 40);
      @(posedge clock);
      #1;
   endtask : mode_to
   initial begin
      repeat (16) @(posedge clock);
      rst <= 1'b0;
      repeat (2) @(posedge clock);
      rdc(CKP_ADDR_RELOAD, CKP_RELOAD_RST);
      rdc(CKP_ADDR_SPI_CTRL, 8'h00);
      rdc(CKP_ADDR_SPEED_CTRL, 8'h00);
      rdc(8'h90, 8'h00);
      chk(16'(per), 16'(CKP_PERIODS_STD));
      period(8'hff, 16);
      wrr(CKP_ADDR_RELOAD, 8'h00);
      period(8'h00, 16);
      wrr(CKP_ADDR_SPEED_CTRL, 8'h7e);
      wrr(CKP_ADDR_RELOAD, 8'h80);
      #1 chk(16'(fast), 16'h0);
      period(8'h80, 16);
      wrr(CKP_ADDR_SPI_CTRL, 8'h01);
      mode_to(8'h2b);
      chk(16'(per), 16'(CKP_PERIODS_FAST));
      chk(16'(fast), 16'h54);
      rdc(CKP_ADDR_SPEED_CTRL, 8'h2b);
      period(8'h80, 8);
      wrr(CKP_ADDR_RELOAD, 8'hff);
      period(8'hff, 8);
      wrr(CKP_ADDR_RELOAD, 8'h00);
      period(8'h00, 8);
      mode_to(8'h00);
      chk(16'(fast), 16'h0);
      @(posedge clock);
      rst  <= 1'b1;
      fuse <= 1'b1;
      repeat (2) @(posedge clock);
      rst  <= 1'b0;
      wdata <= 8'h01;
      wt(1'b1, 40);
      rdc(CKP_ADDR_SPEED_CTRL, 8'h01);
      test_done();
   end
endmodule : tb
